// ### mmpc_cfg.svh
// constants of the memory map paging controller
// assumes one system bus clock and a synchronous active-high reset
// Notes on behaviour
// - The page index leaves reset at 0xE so local 0x0000-0xFFFF is one linear flash region.
// - Local 0xC000-0xFFFF always maps to global page 0xF whatever the page index holds.
// - Normal single chip mode runs application code from inside and drives no external bus.
// - Special single chip mode starts in active debug mode with debug firmware in control.
// - Debug tables and registers are selected only in debug read and write cycles.
// - In active debug mode the debug resources appear at local 0xFF00-0xFFFF.
// - In active debug mode resources sharing the debug range are hidden from the map.
// - In active debug mode with page index 0x0F debug resources also appear at 0xBF00-0xBFFF.
// - The four-bit page index selects one of sixteen 16KB blocks for the window at 0x8000.
`ifndef MMPC_CFG_SVH
`define MMPC_CFG_SVH
`define MMPC_PAGE_RST 4'hE
`define MMPC_PAGE_FIXED 4'hF
`define MMPC_PAGE_DBG_ALIAS 4'hF
`define MMPC_LOW0_PAGE 4'hC
`define MMPC_LOW1_PAGE 4'hD
`define MMPC_REGION_LOW0 2'h0
`define MMPC_REGION_LOW1 2'h1
`define MMPC_REGION_WINDOW 2'h2
`define MMPC_DBG_HI_BASE 8'hFF
`define MMPC_DBG_ALIAS_BASE 8'hBF
`define MMPC_STRAP_WAIT 2'h3
`define MMPC_STRAP_SPECIAL 1'b0
`endif

// ### mmpc_pkg.sv
// types shared by the memory map paging controller files
// assumes the constants header supplies all numeric values
package mmpc_pkg;
  typedef struct packed {
    logic valid;
    logic write;
    logic [15:0] addr;
  } mmpc_cpu_req_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic dbg_sel;
    logic res_sel;
    logic [17:0] addr;
  } mmpc_glb_req_t;

  typedef enum logic [2:0] {
    MMPC_ST_INIT = 3'h1,
    MMPC_ST_USER = 3'h2,
    MMPC_ST_DEBUG = 3'h4
  } mmpc_state_t;
endpackage

// ### mmpc_xlate.sv
// local to global address translation, purely combinational
// assumes page index and debug state come from registers of the caller
`timescale 1ns/1ps
`default_nettype none
`include "mmpc_cfg.svh"
module mmpc_xlate (
  input wire logic [15:0] addr_i,
  input wire logic [3:0] program_page_index_i,
  input wire logic dbg_active_i,
  input wire logic dbg_cycle_i,
  output logic [17:0] glb_addr_o,
  output logic dbg_sel_o,
  output logic res_sel_o
);
  logic [3:0] page;
  logic dbg_window;

  always_comb begin
    case (addr_i[15:14])
      `MMPC_REGION_LOW0: page = `MMPC_LOW0_PAGE;
      `MMPC_REGION_LOW1: page = `MMPC_LOW1_PAGE;
      `MMPC_REGION_WINDOW: page = program_page_index_i;
      default: page = `MMPC_PAGE_FIXED;
    endcase
    glb_addr_o = {page, addr_i[13:0]};
    dbg_window = dbg_active_i &&
      ((addr_i[15:8] == `MMPC_DBG_HI_BASE) ||
       ((addr_i[15:8] == `MMPC_DBG_ALIAS_BASE) &&
        (program_page_index_i == `MMPC_PAGE_DBG_ALIAS)));
    dbg_sel_o = dbg_window && dbg_cycle_i;
    // user code never sees debug resources, shared ones vanish in debug
    res_sel_o = !dbg_window;
  end
endmodule
`default_nettype wire

// ### mmpc_top.sv
// memory map paging controller: mode selection, paging and debug visibility
// assumes cpu requests and debug cycle strobes arrive on sys_clk_i
// mode strap and background debug pin are asynchronous and synchronised here
// every output is a register; requests seen before the strap has been read are dropped
`timescale 1ns/1ps
`default_nettype none
`include "mmpc_cfg.svh"
module mmpc_top (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic mode_strap_i,
  input wire logic background_debug_pin_i,
  input wire mmpc_pkg::mmpc_cpu_req_t cpu_req_i,
  input wire logic page_wr_i,
  input wire logic [3:0] page_data_i,
  input wire logic debug_read_cycle_i,
  input wire logic debug_write_cycle_i,
  input wire logic debug_entry_i,
  input wire logic debug_exit_i,
  output mmpc_pkg::mmpc_glb_req_t glb_req_o,
  output logic [3:0] program_page_index_o,
  output logic background_debug_mode_o,
  output logic special_mode_o,
  output logic app_run_o,
  output logic ext_bus_en_o,
  output logic background_debug_pin_o
);
  // pin synchronisers
  // reset to the idle high level, which reads as normal mode and an idle pin
  logic strap_s1_q;
  logic strap_s2_q;
  logic background_debug_pin_s1_q;
  logic background_debug_pin_s2_q;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      strap_s1_q <= 1'b1;
      strap_s2_q <= 1'b1;
      background_debug_pin_s1_q <= 1'b1;
      background_debug_pin_s2_q <= 1'b1;
    end else begin
      strap_s1_q <= mode_strap_i;
      strap_s2_q <= strap_s1_q;
      background_debug_pin_s1_q <= background_debug_pin_i;
      background_debug_pin_s2_q <= background_debug_pin_s1_q;
    end
  end

  // mode and debug state
  mmpc_pkg::mmpc_state_t state_q;
  mmpc_pkg::mmpc_state_t state_d;
  logic [1:0] wait_q;
  logic [1:0] wait_d;
  logic special_q;
  logic special_d;

  always_comb begin
    state_d = state_q;
    wait_d = wait_q;
    special_d = special_q;
    case (state_q)
      mmpc_pkg::MMPC_ST_INIT: begin
        // strap needs the synchroniser to fill before it is trusted
        if (wait_q == `MMPC_STRAP_WAIT) begin
          special_d = (strap_s2_q == `MMPC_STRAP_SPECIAL);
          if (strap_s2_q == `MMPC_STRAP_SPECIAL) begin
            state_d = mmpc_pkg::MMPC_ST_DEBUG;
          end else begin
            state_d = mmpc_pkg::MMPC_ST_USER;
          end
        end else begin
          wait_d = wait_q + 2'h1;
        end
      end
      mmpc_pkg::MMPC_ST_USER: begin
        // user code leaves only on an entry request from the debug logic
        if (debug_entry_i) begin
          state_d = mmpc_pkg::MMPC_ST_DEBUG;
        end
      end
      mmpc_pkg::MMPC_ST_DEBUG: begin
        // entry wins if both arrive together
        if (debug_exit_i && !debug_entry_i) begin
          state_d = mmpc_pkg::MMPC_ST_USER;
        end
      end
      default: begin
        // an illegal code restarts the mode decision
        state_d = mmpc_pkg::MMPC_ST_INIT;
        wait_d = 2'h0;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      state_q <= mmpc_pkg::MMPC_ST_INIT;
      wait_q <= 2'h0;
      special_q <= 1'b0;
    end else begin
      state_q <= state_d;
      wait_q <= wait_d;
      special_q <= special_d;
    end
  end

  // program page index
  logic [3:0] page_q;
  logic [3:0] page_d;

  always_comb begin
    page_d = page_q;
    // a write takes effect for the very next request
    if (page_wr_i) begin
      page_d = page_data_i;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      page_q <= `MMPC_PAGE_RST;
    end else begin
      page_q <= page_d;
    end
  end

  // translation of the current request
  logic dbg_active;
  logic dbg_cycle;
  logic [17:0] xl_addr;
  logic xl_dbg_sel;
  logic xl_res_sel;

  assign dbg_active = (state_q == mmpc_pkg::MMPC_ST_DEBUG);
  // debug strobes qualify only the debug select line, never the resource select or the address map
  assign dbg_cycle = debug_read_cycle_i || debug_write_cycle_i;

  mmpc_xlate u_xlate (
    .addr_i(cpu_req_i.addr),
    .program_page_index_i(page_q),
    .dbg_active_i(dbg_active),
    .dbg_cycle_i(dbg_cycle),
    .glb_addr_o(xl_addr),
    .dbg_sel_o(xl_dbg_sel),
    .res_sel_o(xl_res_sel)
  );

  // registered outputs: translated request
  mmpc_pkg::mmpc_glb_req_t glb_q;
  mmpc_pkg::mmpc_glb_req_t glb_d;

  // requests seen before the mode is known are dropped, not queued
  always_comb begin
    glb_d.valid = cpu_req_i.valid && (state_q != mmpc_pkg::MMPC_ST_INIT);
    glb_d.write = cpu_req_i.write;
    glb_d.addr = xl_addr;
    glb_d.dbg_sel = glb_d.valid && xl_dbg_sel;
    glb_d.res_sel = glb_d.valid && xl_res_sel;
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      glb_q <= '0;
    end else begin
      glb_q <= glb_d;
    end
  end

  // registered outputs: mode and status
  logic run_q;
  logic run_d;
  logic dbgm_q;
  logic dbgm_d;
  logic spec_q;
  logic spec_d;
  logic ebus_q;
  logic ebus_d;
  logic [3:0] page_o_q;
  logic [3:0] page_o_d;
  logic background_debug_pin_o_q;
  logic background_debug_pin_o_d;

  always_comb begin
    // application code runs only while user state holds the cpu
    run_d = (state_q == mmpc_pkg::MMPC_ST_USER);
    dbgm_d = dbg_active;
    spec_d = special_q;
    // single chip modes only: the external bus is never enabled
    ebus_d = 1'b0;
    // index output follows the write edge, same as the index itself
    page_o_d = page_d;
    background_debug_pin_o_d = background_debug_pin_s2_q;
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      run_q <= 1'b0;
      dbgm_q <= 1'b0;
      spec_q <= 1'b0;
      ebus_q <= 1'b0;
      page_o_q <= `MMPC_PAGE_RST;
      background_debug_pin_o_q <= 1'b1;
    end else begin
      run_q <= run_d;
      dbgm_q <= dbgm_d;
      spec_q <= spec_d;
      ebus_q <= ebus_d;
      page_o_q <= page_o_d;
      background_debug_pin_o_q <= background_debug_pin_o_d;
    end
  end

  assign glb_req_o = glb_q;
  assign program_page_index_o = page_o_q;
  assign background_debug_mode_o = dbgm_q;
  assign special_mode_o = spec_q;
  assign app_run_o = run_q;
  assign ext_bus_en_o = ebus_q;
  assign background_debug_pin_o = background_debug_pin_o_q;
endmodule
`default_nettype wire

// ### mmpc_cpu_model.sv
// cpu side model: one local request per go pulse
// assumes the bench drives go_i and addr_i on the rising edge
`timescale 1ns/1ps
`default_nettype none
module mmpc_cpu_model (
  input wire logic clk_i,
  input wire logic go_i,
  input wire logic [15:0] addr_i,
  output mmpc_pkg::mmpc_cpu_req_t req_o
);
  initial req_o = '0;
  // idle address flips so a stale value never looks valid
  always @(posedge clk_i) begin
    req_o.valid <= go_i;
    req_o.write <= 1'b0;
    req_o.addr <= go_i ? addr_i : ~req_o.addr;
  end
endmodule
`default_nettype wire

// ### mmpc_top_asserts.sv
// output relations of the paging controller
// assumes one clock domain; attached by the bind below
`timescale 1ns/1ps
`default_nettype none
module mmpc_top_asserts (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire mmpc_pkg::mmpc_cpu_req_t cpu_req_i,
  input wire logic page_wr_i,
  input wire logic [3:0] page_data_i,
  input wire logic debug_read_cycle_i,
  input wire logic debug_write_cycle_i,
  input wire mmpc_pkg::mmpc_glb_req_t glb_req_o,
  input wire logic [3:0] program_page_index_o,
  input wire logic background_debug_mode_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  // mode held two cycles, so the answer was formed inside it
  sequence s_dbg;
    background_debug_mode_o && $past(background_debug_mode_o);
  endsequence
  sequence s_usr;
    !background_debug_mode_o && !$past(background_debug_mode_o);
  endsequence
  a_low_bits: assert property (
    glb_req_o.valid |-> glb_req_o.addr[13:0] == $past(cpu_req_i.addr[13:0])) else $error("low bits");
  a_fixed_page: assert property (
    glb_req_o.valid && $past(cpu_req_i.addr[15:14]) == 2'h3 |-> glb_req_o.addr[17:14] == 4'hF)
    else $error("fixed page");
  a_window_page: assert property (
    glb_req_o.valid && $past(cpu_req_i.addr[15:14]) == 2'h2
    |-> glb_req_o.addr[17:14] == $past(program_page_index_o)) else $error("window page");
  a_page_load: assert property (
    page_wr_i |=> program_page_index_o == $past(page_data_i)) else $error("page load");
  a_dbg_strobe: assert property (
    glb_req_o.dbg_sel |-> $past(debug_read_cycle_i) || $past(debug_write_cycle_i))
    else $error("debug select");
  a_user_hidden: assert property (
    s_usr ##0 glb_req_o.valid |-> glb_req_o.res_sel && !glb_req_o.dbg_sel) else $error("user map");
  a_dbg_top: assert property (
    s_dbg ##0 glb_req_o.valid && $past(cpu_req_i.addr[15:8]) == 8'hFF |-> !glb_req_o.res_sel)
    else $error("debug top");
  a_dbg_alias: assert property (
    s_dbg ##0 glb_req_o.valid && $past(cpu_req_i.addr[15:8]) == 8'hBF
    && $past(program_page_index_o) == 4'hF |-> !glb_req_o.res_sel) else $error("debug alias");
endmodule
bind mmpc_top mmpc_top_asserts i_mmpc_top_asserts (.*);
`default_nettype wire

// ### tb_top.sv
// bench of the paging controller in normal and special mode
// assumes design, package and cpu model are compiled first
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  typedef struct {logic m; logic [3:0] p; logic [15:0] a; logic [1:0] d; logic [17:0] g; logic r;}
    mmpc_row_t;
  logic sys_clk, rst, strap, go, pw, ent, ext, rd, wr, background_debug_mode, spec, run, ebus, background_debug_pin, bpo;
  logic [3:0] pd, pidx;
  logic [15:0] la;
  mmpc_pkg::mmpc_cpu_req_t creq;
  mmpc_pkg::mmpc_glb_req_t greq;
  int err_total, total_checks;
  mmpc_row_t rows [11] = '{'{0, 4'hE, 16'h8123, 0, 18'h38123, 1}, '{0, 4'hE, 16'h0123, 0, 18'h30123, 1},
    '{0, 4'h0, 16'h8000, 0, 18'h00000, 1}, '{0, 4'hF, 16'hBFFF, 1, 18'h3FFFF, 1},
    '{0, 4'h3, 16'hC00F, 0, 18'h3C00F, 1}, '{0, 4'hA, 16'hFF10, 2, 18'h3FF10, 1},
    '{1, 4'hF, 16'hFF00, 1, 18'h3FF00, 0}, '{1, 4'hF, 16'hFFFF, 0, 18'h3FFFF, 0},
    '{1, 4'hF, 16'hBF00, 2, 18'h3FF00, 0}, '{1, 4'hE, 16'hBF80, 1, 18'h3BF80, 1},
    '{0, 4'h3, 16'h8001, 0, 18'h0C001, 1}};
  mmpc_cpu_model i_mmpc_cpu_model (.clk_i(sys_clk), .go_i(go), .addr_i(la), .req_o(creq));
  mmpc_top i_mmpc_top (.sys_clk_i(sys_clk), .rst_i(rst), .mode_strap_i(strap),
    .background_debug_pin_i(background_debug_pin), .cpu_req_i(creq), .page_wr_i(pw), .page_data_i(pd),
    .debug_read_cycle_i(rd), .debug_write_cycle_i(wr), .debug_entry_i(ent), .debug_exit_i(ext),
    .glb_req_o(greq), .program_page_index_o(pidx), .background_debug_mode_o(background_debug_mode),
    .special_mode_o(spec), .app_run_o(run), .ext_bus_en_o(ebus), .background_debug_pin_o(bpo));
  task automatic chk(input logic [17:0] g, input logic [17:0] e);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic close_out;
    if (err_total == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic xfer(input mmpc_row_t w);
    @(posedge sys_clk);
    pd <= w.p;
    pw <= 1'b1;
    la <= w.a;
    go <= 1'b1;
    @(posedge sys_clk);
    pw <= 1'b0;
    go <= 1'b0;
    {wr, rd} <= w.d;
    @(posedge sys_clk);
    {wr, rd} <= 2'h0;
    #1;
    chk(greq.addr, w.g);
    chk(18'({greq.valid, greq.res_sel, greq.dbg_sel}), 18'({1'b1, w.r, !w.r && w.d != 0}));
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  initial begin
    {rst, strap, go, pw, ent, ext, rd, wr} = 8'hC0;
    background_debug_pin = 1'b1;
    pd = 4'h0;
    la = 16'h0;
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    #1;
    chk(18'(pidx), 18'hE);
    repeat (8) @(posedge sys_clk);
    #1 chk(18'({spec, run, ebus}), 18'h2);
    foreach (rows[i]) begin
      if (rows[i].m !== background_debug_mode) begin
        @(posedge sys_clk);
        ent <= rows[i].m;
        ext <= !rows[i].m;
        @(posedge sys_clk);
        ent <= 1'b0;
        ext <= 1'b0;
        repeat (2) @(posedge sys_clk);
        #1 chk(18'({background_debug_mode, run}), 18'({rows[i].m, !rows[i].m}));
      end
      xfer(rows[i]);
    end
    // debug pin level passes two synchroniser stages and the output register
    @(posedge sys_clk);
    background_debug_pin <= 1'b0;
    repeat (2) @(posedge sys_clk);
    #1 chk(18'(bpo), 18'h1);
    @(posedge sys_clk);
    #1 chk(18'(bpo), 18'h0);
    @(posedge sys_clk);
    background_debug_pin <= 1'b1;
    // strap low: core must come up under debug control
    @(posedge sys_clk);
    strap <= 1'b0;
    rst <= 1'b1;
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    #1 chk(18'(pidx), 18'hE);
    repeat (8) @(posedge sys_clk);
    #1 chk(18'({spec, background_debug_mode, run, ebus}), 18'hC);
    close_out;
  end
  initial begin
    repeat (3000) @(posedge sys_clk);
    err_total++;
    close_out;
  end
endmodule
`default_nettype wire
